// *** hw/pds_pkg.sv ***
// constants, types and event codes of the diagnostic supervisor
package pds_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 100_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
  localparam logic [11:0] SCAN_LIMIT_MS_RST = 12'h0C8;
  localparam logic [11:0] WDT_TIMEOUT_MS    = 12'h15E;
  localparam logic [11:0] CAL_PERIOD_MS     = 12'h12C;
  localparam logic [11:0] BLINK_HALF_MS     = 12'h0FA;
  localparam logic [2:0]  RETRY_LIMIT       = 3'h4;
  localparam int          HIST_DEPTH        = 30;
  localparam logic [4:0]  HIST_DEPTH_W      = 5'h1E;
  localparam logic [31:0] CAL_INVALID       = 32'hFFFFFFFF;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_SCAN_LIMIT = 8'h08;
  localparam logic [7:0] OFS_CAL        = 8'h0C;
  localparam logic [7:0] OFS_HIST_SEL   = 8'h10;
  localparam logic [7:0] OFS_HIST_INFO  = 8'h14;
  localparam logic [7:0] OFS_HIST_TIME  = 8'h18;
  localparam logic [7:0] OFS_HIST_COUNT = 8'h1C;
  localparam int CTL_RUN       = 0;
  localparam int CTL_FROM_TERM = 1;
  localparam int CTL_ERR_RESET = 2;
  localparam int CTL_HIST_CLR  = 3;
  localparam int CTL_MEM_CLR   = 4;
  localparam int CTL_ALARM_CLR = 5;
  localparam int CTL_HALT      = 6;

  // ---------------------------------------------------------------
  // events: code recorded is index plus one
  // ---------------------------------------------------------------
  localparam int EV_PON = 0, EV_POFF = 1, EV_PU_ROM = 2, EV_PU_RAM = 3, EV_PU_PERIPH = 4;
  localparam int EV_PU_LANG = 5, EV_PU_PROG = 6, EV_PU_DATA = 7, EV_PU_PMEM = 8, EV_CAL = 9;
  localparam int EV_BATT = 10, EV_RUN_CHK = 11, EV_ILLEGAL = 12, EV_SCAN_OVER = 13, EV_WDT = 14;
  localparam int EV_BG = 15, EV_RETRY = 19, N_BG = 4, N_RETRY = 6, N_EV = 25;
  localparam logic [N_EV-1:0] DOWN_MASK = 25'h007F9E0;
  localparam logic [N_EV-1:0] LOCK_MASK = 25'h00380A0;
  localparam logic [N_EV-1:0] STOP_MASK = 25'h000001C;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PDS_INIT    = 3'b000,
    PDS_HALT    = 3'b001,
    PDS_RUN_CHK = 3'b010,
    PDS_RUN     = 3'b011,
    PDS_FAIL    = 3'b100,
    PDS_STOP    = 3'b101
  } pds_mode_t;

  typedef struct packed {
    logic rom; logic ram; logic periph; logic lang; logic prog; logic data; logic pmem;
  } pds_pu_fail_t;

  typedef struct packed {
    logic [7:0]  code;
    pds_mode_t   mode;
    logic        down;
    logic [31:0] stamp;
  } pds_hist_t;
endpackage : pds_pkg

// *** hw/pds_supervisor.sv ***
// self-diagnosis supervisor with event history and avalon register slave
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// R1: error down forces all outputs off and enters the failure state
// R2: alarm records the error, sets its status bit, keeps running
// R3: each recorded error stores its details and timestamp in history
// R4: power-up firmware check failure records, flashes both leds, blocks terminal
// R5: power-up peripheral readback mismatch records, flashes fault, io steady, blocks terminal
// R6: power-up processor or data memory failure records, fails, ignores error reset
// R7: program memory check after initial load when fitted; failure enters failure state
// R8: peripheral memory check failure at power-up records and enters failure state
// R9: invalid calendar at power-up alarms; date and time read all ones until reset
// R10: low battery alarms but start proceeds when program memory is good
// R11: entering run checks allocation, bus, expansion power, response and syntax
// R12: start check failure records and downs; terminal start stays halted, no record
// R13: scan check failures retry; persistent ones down, recovered ones only record
// R14: bus parity checked on every io access, batch or direct
// R15: illegal instruction records and downs at once without retry
// R16: scan over limit downs; limit 200 ms by default, changeable
// R17: background watchdog 350 ms; expiry records, resets system, then fails
// R18: background rom, ram or peripheral failure downs and locks out error reset
// R19: background user memory check retries; processor check failure downs
// R20: calendar read every 300 ms, validated, copied, alarm when invalid
// R21: history keeps 30 newest entries, newest first, oldest dropped
// R22: history kept until history clear or memory clear command; reset_n also zeroes the entry count, so older entries read as zero
// R23: failure state holds outputs off until accepted error reset or power-up
module pds_supervisor
  import pds_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic         pu_done,
  input  wire pds_pu_fail_t pu_fail,
  input  wire logic         pmem_fitted,
  input  wire logic         init_load_done,
  input  wire logic [31:0]  cal_data,
  input  wire logic         cal_ok,
  input  wire logic         batt_low_pin,
  input  wire logic         power_off_pin,
  input  wire logic         run_chk_done,
  input  wire logic [4:0]   run_chk_fail,
  input  wire logic         scan_start,
  input  wire logic         scan_chk_strobe,
  input  wire logic [4:0]   scan_chk_fail,
  input  wire logic         illegal_instr,
  input  wire logic         wdt_kick,
  input  wire logic [3:0]   bg_fail,
  input  wire logic         bg_umem_strobe,
  input  wire logic         bg_umem_fail,
  output logic              outputs_off,
  output logic              fail_state,
  output logic              fault_led,
  output logic              io_led,
  output logic              comm_block,
  output logic              sys_reset
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  assign pin_raw = {power_off_pin, batt_low_pin};
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_s1_reg[p] <= 1'b0;
          pin_s2_reg[p] <= 1'b0;
          pin_s3_reg[p] <= 1'b0;
          pin_reg[p]    <= 1'b0;
        end else begin
          pin_s1_reg[p] <= pin_raw[p];
          pin_s2_reg[p] <= pin_s1_reg[p];
          pin_s3_reg[p] <= pin_s2_reg[p];
          if (pin_s2_reg[p] == pin_s3_reg[p]) pin_reg[p] <= pin_s3_reg[p];
        end
      end
    end
  endgenerate
  logic       pin_next_batt, pin_next_poff;
  logic       batt_q_reg, poff_q_reg;
  assign pin_next_batt = pin_reg[0];
  assign pin_next_poff = pin_reg[1];

  // ---------------------------------------------------------------
  // state, timers, registers
  // ---------------------------------------------------------------
  pds_mode_t   state_reg, state_next;
  logic [16:0] pre_cnt_reg;
  logic        ms_tick;
  logic [11:0] cal_cnt_reg, wdt_cnt_reg, scan_cnt_reg, blink_cnt_reg;
  logic        blink_reg;
  logic [11:0] scan_limit_reg;
  logic [31:0] cal_time_reg;
  logic        cal_lock_reg, cal_good_reg;
  logic        por_pend_reg, lock_reg, from_term_reg, refused_reg;
  logic        alarm_batt_reg, alarm_cal_reg;
  logic        fault_flash_reg, io_flash_reg, io_on_reg;
  logic [4:0]  hist_sel_reg, hist_cnt_reg;
  pds_hist_t   hist_reg [HIST_DEPTH];
  pds_hist_t   hist_next [HIST_DEPTH];

  assign ms_tick = (pre_cnt_reg == 17'(TICK_CYCLES_P - 1));

  logic active, in_run, init_eval, cal_sample, wdt_expire, scan_over;
  assign active     = (state_reg == PDS_HALT) || (state_reg == PDS_RUN_CHK) || (state_reg == PDS_RUN);
  assign in_run     = (state_reg == PDS_RUN);
  assign init_eval  = (state_reg == PDS_INIT) && pu_done && (!pmem_fitted || init_load_done); // see R7
  assign cal_sample = ms_tick && (cal_cnt_reg == CAL_PERIOD_MS - 12'h001); // see R20
  assign wdt_expire = active && ms_tick && (wdt_cnt_reg == WDT_TIMEOUT_MS - 12'h001); // see R17
  assign scan_over  = in_run && ms_tick && (scan_cnt_reg >= scan_limit_reg - 12'h001); // see R16

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic req, wr_fire, cmd_wr;
  logic [6:0] cmd;
  assign req     = avs_read || avs_write;
  assign wr_fire = avs_write && !avs_waitrequest;
  assign cmd_wr  = wr_fire && (avs_address == OFS_CTRL) && avs_byteenable[0] && !comm_block; // see R4 R5
  assign cmd     = cmd_wr ? avs_writedata[6:0] : 7'h00;

  // ---------------------------------------------------------------
  // retry channels: five scan checks and the background user memory
  // ---------------------------------------------------------------
  logic [N_RETRY-1:0] rt_strobe, rt_fail, rt_first, rt_persist;
  assign rt_strobe = {bg_umem_strobe && active, {5{scan_chk_strobe && in_run}}}; // see R14 R19
  assign rt_fail   = {bg_umem_fail, scan_chk_fail};
  generate
    for (genvar r = 0; r < N_RETRY; r++) begin : g_retry
      logic [2:0] cnt_reg;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt_reg <= 3'h0;
        else if (rt_strobe[r]) cnt_reg <= (rt_fail[r] && cnt_reg != RETRY_LIMIT) ? cnt_reg + 3'h1 : 3'h0;
      end
      assign rt_first[r]   = rt_strobe[r] && rt_fail[r] && (cnt_reg == 3'h0); // see R13
      assign rt_persist[r] = rt_strobe[r] && rt_fail[r] && (cnt_reg == RETRY_LIMIT); // see R13 R19
    end
  endgenerate

  // ---------------------------------------------------------------
  // event requests
  // ---------------------------------------------------------------
  logic [N_EV-1:0] ev_req;
  logic run_fail, term_refuse, batt_rise, poff_rise;
  assign run_fail    = (state_reg == PDS_RUN_CHK) && run_chk_done && (|run_chk_fail); // see R11
  assign term_refuse = run_fail && from_term_reg; // see R12
  assign batt_rise   = pin_next_batt && !batt_q_reg;
  assign poff_rise   = pin_next_poff && !poff_q_reg;
  assign ev_req[EV_PON]       = por_pend_reg; // see R21
  assign ev_req[EV_POFF]      = poff_rise; // see R21
  assign ev_req[EV_PU_ROM]    = init_eval && pu_fail.rom; // see R4
  assign ev_req[EV_PU_RAM]    = init_eval && pu_fail.ram;
  assign ev_req[EV_PU_PERIPH] = init_eval && pu_fail.periph; // see R5
  assign ev_req[EV_PU_LANG]   = init_eval && pu_fail.lang; // see R6
  assign ev_req[EV_PU_PROG]   = init_eval && pu_fail.prog; // see R7
  assign ev_req[EV_PU_DATA]   = init_eval && pu_fail.data; // see R6
  assign ev_req[EV_PU_PMEM]   = init_eval && pu_fail.pmem; // see R8
  assign ev_req[EV_CAL]       = (init_eval && !cal_ok) || (cal_sample && !cal_ok && cal_good_reg); // see R9 R20
  assign ev_req[EV_BATT]      = (init_eval && pin_next_batt) || (active && batt_rise); // see R10
  assign ev_req[EV_RUN_CHK]   = run_fail && !from_term_reg; // see R12
  assign ev_req[EV_ILLEGAL]   = in_run && illegal_instr; // see R15
  assign ev_req[EV_SCAN_OVER] = scan_over; // see R16
  assign ev_req[EV_WDT]       = wdt_expire; // see R17
  assign ev_req[EV_BG+N_BG-1:EV_BG]       = active ? bg_fail : 4'h0; // see R18 R19
  assign ev_req[EV_RETRY+N_RETRY-1:EV_RETRY] = rt_first | rt_persist;

  function automatic logic [7:0] pds_pick(input logic [N_EV-1:0] r);
    logic [7:0] code;
    code = 8'h00;
    for (int i = N_EV - 1; i >= 0; i--) begin
      if (r[i]) code = 8'(i + 1);
    end
    return code;
  endfunction : pds_pick

  logic      rec, down_now, lock_now, stop_now, pu_ok;
  pds_hist_t rec_entry;
  assign down_now = (|(ev_req & DOWN_MASK)) || (|rt_persist); // see R1 R13
  assign lock_now = |(ev_req & LOCK_MASK); // see R6 R18
  assign stop_now = |(ev_req & STOP_MASK);
  assign pu_ok    = !(|pu_fail);
  assign rec      = |ev_req; // see R3
  assign rec_entry.code  = pds_pick(ev_req);
  assign rec_entry.mode  = state_reg;
  assign rec_entry.down  = down_now || stop_now;
  assign rec_entry.stamp = cal_time_reg; // see R3

  // ---------------------------------------------------------------
  // history shift: newest at entry zero
  // ---------------------------------------------------------------
  generate
    for (genvar h = 0; h < HIST_DEPTH; h++) begin : g_hist
      if (h == 0) begin : g_head
        assign hist_next[h] = rec ? rec_entry : hist_reg[h];
      end else begin : g_body
        assign hist_next[h] = rec ? hist_reg[h-1] : hist_reg[h]; // see R21
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    hist_reg <= hist_next;
  end

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PDS_INIT: begin
        if (init_eval) begin
          if (pu_fail.rom || pu_fail.ram || pu_fail.periph) state_next = PDS_STOP; // see R4 R5
          else if (!pu_ok) state_next = PDS_FAIL; // see R6 R7 R8
          else state_next = PDS_HALT; // see R10
        end
      end
      PDS_HALT: begin
        if (cmd[CTL_RUN]) state_next = PDS_RUN_CHK;
      end
      PDS_RUN_CHK: begin
        if (run_chk_done) state_next = run_fail ? (from_term_reg ? PDS_HALT : PDS_FAIL) : PDS_RUN; // see R12
      end
      PDS_RUN: begin
        if (cmd[CTL_HALT]) state_next = PDS_HALT;
      end
      PDS_FAIL: begin
        if (cmd[CTL_ERR_RESET] && !lock_reg) state_next = PDS_HALT; // see R23
      end
      PDS_STOP: state_next = PDS_STOP;
      default:  state_next = PDS_INIT;
    endcase
    if (active && (down_now || wdt_expire)) state_next = PDS_FAIL; // see R1 R17
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= PDS_INIT;
      por_pend_reg <= 1'b1;
      batt_q_reg   <= 1'b0;
      poff_q_reg   <= 1'b0;
      lock_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      por_pend_reg <= 1'b0;
      batt_q_reg   <= pin_next_batt;
      poff_q_reg   <= pin_next_poff;
      if (lock_now) lock_reg <= 1'b1; // see R6 R18
      else if (state_reg == PDS_INIT) lock_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_reg   <= 17'h00000;
      cal_cnt_reg   <= 12'h000;
      wdt_cnt_reg   <= 12'h000;
      scan_cnt_reg  <= 12'h000;
      blink_cnt_reg <= 12'h000;
      blink_reg     <= 1'b0;
    end else begin
      pre_cnt_reg <= ms_tick ? 17'h00000 : pre_cnt_reg + 17'h00001;
      if (ms_tick) cal_cnt_reg <= cal_sample ? 12'h000 : cal_cnt_reg + 12'h001;
      if (!active || wdt_kick) wdt_cnt_reg <= 12'h000; // see R17
      else if (ms_tick) wdt_cnt_reg <= wdt_cnt_reg + 12'h001;
      if (!in_run || scan_start) scan_cnt_reg <= 12'h000; // see R16
      else if (ms_tick) scan_cnt_reg <= scan_cnt_reg + 12'h001;
      if (ms_tick) begin
        blink_cnt_reg <= (blink_cnt_reg == BLINK_HALF_MS - 12'h001) ? 12'h000 : blink_cnt_reg + 12'h001;
        if (blink_cnt_reg == BLINK_HALF_MS - 12'h001) blink_reg <= !blink_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // calendar, alarms, software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_time_reg   <= CAL_INVALID;
      cal_lock_reg   <= 1'b0;
      cal_good_reg   <= 1'b1;
      alarm_batt_reg <= 1'b0;
      alarm_cal_reg  <= 1'b0;
      scan_limit_reg <= SCAN_LIMIT_MS_RST;
      hist_sel_reg   <= 5'h00;
      hist_cnt_reg   <= 5'h00;
      from_term_reg  <= 1'b0;
      refused_reg    <= 1'b0;
    end else begin
      if (init_eval && !cal_ok) cal_lock_reg <= 1'b1; // see R9
      if (init_eval || cal_sample) begin
        cal_good_reg <= cal_ok;
        if (!cal_ok || cal_lock_reg || (init_eval && !cal_ok)) cal_time_reg <= CAL_INVALID; // see R9
        else cal_time_reg <= cal_data; // see R20
      end
      if (ev_req[EV_BATT]) alarm_batt_reg <= 1'b1; // see R2 R10
      else if (cmd[CTL_ALARM_CLR]) alarm_batt_reg <= 1'b0;
      if (ev_req[EV_CAL] || (cal_sample && !cal_ok)) alarm_cal_reg <= 1'b1; // see R2 R20
      else if (cmd[CTL_ALARM_CLR]) alarm_cal_reg <= 1'b0;
      if (wr_fire && avs_address == OFS_SCAN_LIMIT) begin
        if (avs_byteenable[0]) scan_limit_reg[7:0] <= avs_writedata[7:0]; // see R16
        if (avs_byteenable[1]) scan_limit_reg[11:8] <= avs_writedata[11:8];
      end
      if (wr_fire && avs_address == OFS_HIST_SEL && avs_byteenable[0]) hist_sel_reg <= avs_writedata[4:0];
      if (cmd[CTL_HIST_CLR] || cmd[CTL_MEM_CLR]) hist_cnt_reg <= rec ? 5'h01 : 5'h00; // see R22
      else if (rec && hist_cnt_reg != HIST_DEPTH_W) hist_cnt_reg <= hist_cnt_reg + 5'h01; // see R21
      if (state_reg == PDS_HALT && cmd[CTL_RUN]) from_term_reg <= cmd[CTL_FROM_TERM];
      if (term_refuse) refused_reg <= 1'b1; // see R12
      else if (cmd[CTL_RUN]) refused_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // indicator and pin outputs
  // ---------------------------------------------------------------
  logic stop_entry, fail_next;
  assign stop_entry = init_eval && (pu_fail.rom || pu_fail.ram || pu_fail.periph);
  assign fail_next  = (state_next == PDS_FAIL);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_flash_reg <= 1'b0;
      io_flash_reg    <= 1'b0;
      io_on_reg       <= 1'b0;
      comm_block      <= 1'b0;
      outputs_off     <= 1'b1;
      fail_state      <= 1'b0;
      fault_led       <= 1'b0;
      io_led          <= 1'b0;
      sys_reset       <= 1'b0;
    end else begin
      if (stop_entry) begin
        fault_flash_reg <= 1'b1; // see R4 R5
        io_flash_reg    <= pu_fail.rom; // see R4
        io_on_reg       <= !pu_fail.rom && pu_fail.periph; // see R5
        comm_block      <= 1'b1; // see R4 R5
      end
      outputs_off <= fail_next || (state_next == PDS_STOP) || (state_next == PDS_INIT); // see R1 R23
      fail_state  <= fail_next; // see R1 R23
      fault_led   <= fault_flash_reg ? blink_reg : (state_reg == PDS_FAIL);
      io_led      <= io_flash_reg ? blink_reg : io_on_reg;
      sys_reset   <= wdt_expire; // see R17
    end
  end

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, unmapped reads zero
  // ---------------------------------------------------------------
  pds_hist_t   sel_entry;
  logic        sel_valid;
  logic [31:0] rd_mux;
  assign sel_entry = hist_reg[hist_sel_reg < HIST_DEPTH_W ? hist_sel_reg : 5'h00];
  assign sel_valid = hist_sel_reg < hist_cnt_reg;
  always_comb begin
    case (avs_address)
      OFS_STATUS:     rd_mux = {21'h000000, state_reg, lock_reg, comm_block, alarm_batt_reg,
                                alarm_cal_reg, refused_reg, outputs_off, cal_lock_reg, fail_state};
      OFS_SCAN_LIMIT: rd_mux = {20'h00000, scan_limit_reg};
      OFS_CAL:        rd_mux = cal_time_reg; // see R20
      OFS_HIST_SEL:   rd_mux = {27'h0000000, hist_sel_reg};
      OFS_HIST_INFO:  rd_mux = sel_valid ? {20'h00000, sel_entry.down, sel_entry.mode, sel_entry.code} : 32'h0;
      OFS_HIST_TIME:  rd_mux = sel_valid ? sel_entry.stamp : 32'h00000000;
      OFS_HIST_COUNT: rd_mux = {27'h0000000, hist_cnt_reg};
      default:        rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end
endmodule : pds_supervisor

// *** verification/pds_sup_asserts.sv ***
// assertion checker of the diagnostic supervisor ports
`timescale 1ns/100ps
module pds_sup_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        outputs_off,
  input wire logic        fail_state,
  input wire logic        sys_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_once_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  fail_off_a: assert property (fail_state |-> outputs_off)
    else $error("outputs on in failure state");
  fail_hold_a: assert property (fail_state && !avs_write |=> fail_state)
    else $error("failure state left without command");
  rst_fail_a: assert property (sys_reset |-> fail_state ##1 !sys_reset)
    else $error("watchdog reset not a pulse into failure");
  rst_src_a: assert property (sys_reset |-> !$past(outputs_off))
    else $error("watchdog expiry outside active mode");
endmodule : pds_sup_asserts
bind pds_supervisor pds_sup_asserts u_chk (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .outputs_off, .fail_state, .sys_reset);

// *** verification/pds_far_model.sv ***
// far side: power-up checks, calendar, watchdog kicks, scan pacing, run check answers
`timescale 1ns/100ps
module pds_far_model
  import pds_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset_n,
  input  wire logic   kick_en,
  input  wire logic   go,
  input  wire logic [4:0] go_fail,
  output logic         pu_done,
  output pds_pu_fail_t pu_fail,
  output logic [31:0]  cal_data,
  output logic         cal_ok,
  output logic         wdt_kick,
  output logic         scan_start,
  output logic         run_chk_done,
  output logic [4:0]   run_chk_fail
);
  logic [5:0] cnt_reg;
  logic [3:0] dly_reg;
  assign pu_fail      = '0;
  assign cal_data     = 32'h24061530;
  assign cal_ok       = 1'b1;
  assign wdt_kick     = kick_en && cnt_reg == 6'h3F;
  assign scan_start   = cnt_reg == 6'h20;
  assign run_chk_done = dly_reg == 4'h1;
  assign run_chk_fail = go_fail;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 6'h00;
      dly_reg <= 4'h0;
      pu_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
      pu_done <= pu_done | cnt_reg[3];
      dly_reg <= go ? 4'h8 : dly_reg - {3'h0, |dly_reg};
    end
  end
endmodule : pds_far_model

// *** verification/tb.sv ***
// self-checking bench of the diagnostic supervisor
`timescale 1ns/100ps
module tb;
  import pds_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, ill = 1'b0, str = 1'b0, go = 1'b0, kick_en = 1'b1;
  logic [4:0]   go_fail = 5'h00, chk_fail, sfail = 5'h01;
  logic [3:0]   be = 4'hF, bgf = 4'h0;
  logic         batt = 1'b0, ustr = 1'b0, ufail = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0, rdat, cal, q;
  logic         waitreq, outs_off, fail_st, sys_rst, pu_done, cal_ok, kick, scan_go, chk_done, fled, iled, cblk;
  pds_pu_fail_t pu_fail;
  int           fails = 0, tests_run = 0, cyc = 0;
  pds_far_model far (.clk, .reset_n, .kick_en, .go, .go_fail, .pu_done, .pu_fail, .cal_data(cal), .cal_ok,
    .wdt_kick(kick), .scan_start(scan_go), .run_chk_done(chk_done), .run_chk_fail(chk_fail));
  pds_supervisor #(.TICK_CYCLES_P(10)) DUT (.clk, .reset_n, .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(waitreq), .pu_done,
    .pu_fail, .pmem_fitted(1'b0), .init_load_done(1'b1), .cal_data(cal), .cal_ok, .batt_low_pin(batt),
    .power_off_pin(1'b0), .run_chk_done(chk_done), .run_chk_fail(chk_fail), .scan_start(scan_go),
    .scan_chk_strobe(str), .scan_chk_fail(sfail), .illegal_instr(ill), .wdt_kick(kick), .bg_fail(bgf),
    .bg_umem_strobe(ustr), .bg_umem_fail(ufail), .outputs_off(outs_off), .fail_state(fail_st),
    .fault_led(fled), .io_led(iled), .comm_block(cblk), .sys_reset(sys_rst));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (waitreq) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q & m, e);
  endtask : rchk
  task automatic start(input logic [31:0] c, input logic [4:0] f);
    bus(1'b1, OFS_CTRL, c);
    go_fail <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : start
  task automatic pulse_ill();
    ill <= 1'b1;
    @(posedge clk);
    ill <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_ill
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (30) @(posedge clk);
    rchk("count", OFS_HIST_COUNT, 32'hFF, 32'h1);
    rchk("limit", OFS_SCAN_LIMIT, 32'hFFF, 32'h0C8);
    rchk("cal", OFS_CAL, 32'hFFFFFFFF, 32'h24061530);
    rchk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
    be <= 4'h1;
    bus(1'b1, OFS_SCAN_LIMIT, 32'h1FA);
    be <= 4'hF;
    rchk("limit", OFS_SCAN_LIMIT, 32'hFFF, 32'h0FA);
    start(32'h1, 5'h00);
    rchk("mode", OFS_STATUS, 32'h700, 32'h300);
    for (int i = 0; i < 5; i++) begin
      chk("fail", {31'h0, fail_st}, 32'h0);
      str <= 1'b1;
      @(posedge clk);
      str <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk("down", {30'h0, fail_st, outs_off}, 32'h3);
    rchk("count", OFS_HIST_COUNT, 32'hFF, 32'h3);
    rchk("info", OFS_HIST_INFO, 32'h8FF, 32'h814);
    bus(1'b1, OFS_CTRL, 32'h4);
    rchk("mode", OFS_STATUS, 32'h701, 32'h100);
    start(32'h3, 5'h01);
    rchk("refused", OFS_STATUS, 32'h708, 32'h108);
    rchk("count", OFS_HIST_COUNT, 32'hFF, 32'h3);
    start(32'h1, 5'h00);
    pulse_ill();
    chk("down", {30'h0, fail_st, outs_off}, 32'h3);
    chk("leds", {29'h0, cblk, fled, iled}, 32'h2);
    rchk("info", OFS_HIST_INFO, 32'hFF, 32'h0D);
    bus(1'b1, OFS_CTRL, 32'h4);
    kick_en <= 1'b0;
    while (!sys_rst) @(posedge clk);
    chk("wdt", {31'h0, fail_st}, 32'h1);
    kick_en <= 1'b1;
    rchk("info", OFS_HIST_INFO, 32'hFF, 32'h0F);
    bus(1'b1, OFS_CTRL, 32'h4);
    bus(1'b1, OFS_CTRL, 32'h8);
    rchk("count", OFS_HIST_COUNT, 32'hFF, 32'h0);
    batt <= 1'b1;
    repeat (8) @(posedge clk);
    rchk("batt", OFS_STATUS, 32'h721, 32'h120);
    rchk("count", OFS_HIST_COUNT, 32'hFF, 32'h1);
    bgf <= 4'h1;
    @(posedge clk);
    bgf <= 4'h0;
    bus(1'b1, OFS_CTRL, 32'h4);
    rchk("lock", OFS_STATUS, 32'h781, 32'h481);
    final_report();
  end
endmodule : tb
